// *** core/sbs_sram.sv ***
// Pipelined burst SRAM core with burst address sequencer
`timescale 1ns/1ps
`include "sbs_cfg.svh"
module sbs_sram import sbs_pkg::*; #(
  parameter int AW    = `SBS_ADDR_W,
  parameter int DW    = `SBS_DATA_W,
  parameter int LANES = `SBS_LANES,
  parameter int DEPTH = 64
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic [AW-1:0]    addr,
  input  wire logic             addr_load,
  input  wire logic             chip_enable_n,
  input  wire logic             second_select_n,
  input  wire logic             high_select,
  input  wire logic             burst_advance_n,
  input  wire logic             write_n,
  input  wire logic [LANES-1:0] byte_lane_write_n,
  input  wire logic             burst_order_select,
  input  wire logic             sleep_request,
  input  wire logic             output_enable_n,
  input  wire logic [DW-1:0]    data_in,
  output logic [DW-1:0]         data_out,
  output logic                  data_oe_n,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic [DW-1:0]         rd_data,
  output logic                  cfg_ready
);
  localparam int LW = DW / LANES;
  localparam int IW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] base;
    logic [1:0]    cnt;
    sbs_op_t       op;
    logic [DW-1:0] dout;
    logic          dvalid;
    logic          dstb;
    logic          pend;
    logic [3:0]    cfg_cnt;
  } sbs_st_t;
  sbs_st_t s_q, s_d;
  logic [DW-1:0] mem_q [DEPTH];
  logic          sel;
  logic [1:0]    low;
  logic [AW-1:0] cur;
  logic          buf_ready;
  logic          wr_now;
  logic          fetch;
  logic [1:0]    nlow;
  assign sel = !chip_enable_n && !second_select_n && high_select && !sleep_request;
  always_comb begin
    if (burst_order_select) begin
      low = s_q.base[1:0] ^ s_q.cnt;
    end else begin
      low = s_q.base[1:0] + s_q.cnt;
    end
  end
  assign cur = {s_q.base[AW-1:2], low};
  assign wr_now = (s_q.op == SBS_WRITE) && !write_n;
  // One fetch per read load or read advance; those made while a word is held merge into one fetch, and a word not taken by the buffer is held
  always_comb begin
    s_d      = s_q;
    fetch    = 1'b0;
    nlow     = 2'h0;
    s_d.dstb = s_q.dstb && !buf_ready;
    if (s_q.cfg_cnt != 4'(`SBS_CFG_CYC)) begin
      s_d.cfg_cnt = s_q.cfg_cnt + 4'h1;
    end
    if (sleep_request) begin
      s_d.op = SBS_IDLE;
    end else if (addr_load) begin
      if (sel) begin
        s_d.base = addr;
        s_d.cnt  = 2'h0;
        s_d.op   = write_n ? SBS_READ : SBS_WRITE;
        s_d.pend = write_n;
      end else begin
        s_d.op = SBS_IDLE;
      end
    end else if (!burst_advance_n && s_q.op != SBS_IDLE) begin
      // Wrap to start after fourth word
      s_d.cnt  = s_q.cnt + 2'h1;
      s_d.pend = (s_q.op == SBS_READ);
    end
    if (s_d.op != SBS_READ) begin
      s_d.pend   = 1'b0;
      s_d.dvalid = 1'b0;
    end
    if (burst_order_select) begin
      nlow = s_d.base[1:0] ^ s_d.cnt;
    end else begin
      nlow = s_d.base[1:0] + s_d.cnt;
    end
    // Read data registered on the same edge that captures the address
    if (s_d.pend && !s_d.dstb) begin
      s_d.dout   = mem_q[IW'({s_d.base[AW-1:2], nlow})];
      s_d.dvalid = 1'b1;
      s_d.dstb   = 1'b1;
      s_d.pend   = 1'b0;
      fetch      = 1'b1;
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < LANES; i++) begin
      if (wr_now && !byte_lane_write_n[i]) begin
        mem_q[IW'(cur)][i*LW +: LW] <= data_in[i*LW +: LW];
      end
    end
  end
  assign data_out  = s_q.dout;
  assign data_oe_n = output_enable_n || !s_q.dvalid;
  assign cfg_ready = (s_q.cfg_cnt == 4'(`SBS_CFG_CYC));
  sbs_buf2 #(.W(DW)) u_buf (
    .clk      (ref_clk),
    .rstn     (rstn),
    .in_valid (s_q.dstb),
    .in_ready (buf_ready),
    .in_data  (s_q.dout),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data (rd_data)
  );
  property p_rd_lat;
    @(posedge ref_clk) disable iff (!rstn)
      fetch |=> (s_q.dvalid && s_q.dstb);
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("Read data late");
  property p_wrap;
    @(posedge ref_clk) disable iff (!rstn)
      (s_q.cnt == 2'h3 && !burst_advance_n && !addr_load && !sleep_request
       && s_q.op != SBS_IDLE) |=> (low == s_q.base[1:0]);
  endproperty
  a_wrap: assert property (p_wrap) else $error("Burst did not wrap");
  property p_lin;
    @(posedge ref_clk) disable iff (!rstn)
      !burst_order_select |-> (low == 2'(s_q.base[1:0] + s_q.cnt));
  endproperty
  a_lin: assert property (p_lin) else $error("Linear order wrong");
  property p_ilv;
    @(posedge ref_clk) disable iff (!rstn)
      burst_order_select |-> (low == (s_q.base[1:0] ^ s_q.cnt));
  endproperty
  a_ilv: assert property (p_ilv) else $error("Interleaved order wrong");
  property p_hi;
    @(posedge ref_clk) disable iff (!rstn)
      cur[AW-1:2] == s_q.base[AW-1:2];
  endproperty
  a_hi: assert property (p_hi) else $error("Upper bits moved");
  property p_sel;
    @(posedge ref_clk) disable iff (!rstn)
      (addr_load && !sleep_request && (chip_enable_n || second_select_n || !high_select))
        |=> s_q.op == SBS_IDLE;
  endproperty
  a_sel: assert property (p_sel) else $error("Select decode wrong");
  property p_oe;
    @(posedge ref_clk) disable iff (!rstn)
      output_enable_n |-> data_oe_n;
  endproperty
  a_oe: assert property (p_oe) else $error("Drivers on while disabled");
  property p_cfg;
    @(posedge ref_clk) disable iff (!rstn)
      $rose(cfg_ready) |-> $past(s_q.cfg_cnt) == 4'(`SBS_CFG_CYC - 1);
  endproperty
  a_cfg: assert property (p_cfg) else $error("Config count wrong");
endmodule : sbs_sram

// *** core/sbs_cfg.svh ***
// Constants for the burst sequencer
`ifndef SBS_CFG_SVH
`define SBS_CFG_SVH
`define SBS_ADDR_W      19
`define SBS_DATA_W      36
`define SBS_LANES       4
`define SBS_BURST_LEN   4
`define SBS_CFG_TIME_NS 24
`define SBS_CLK_NS      10
`define SBS_CFG_CYC     ((`SBS_CFG_TIME_NS + `SBS_CLK_NS - 1) / `SBS_CLK_NS)
`endif

// *** core/sbs_pkg.sv ***
// Types for the burst sequencer
package sbs_pkg;
  typedef enum logic [1:0] {SBS_IDLE, SBS_READ, SBS_WRITE} sbs_op_t;
endpackage : sbs_pkg

// *** core/sbs_buf2.sv ***
// Two-entry valid/ready buffer for read data
`timescale 1ns/1ps
module sbs_buf2 #(
  parameter int W = 36
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  typedef struct packed {
    logic [1:0]   cnt;
    logic [W-1:0] d0;
    logic [W-1:0] d1;
  } sbs_buf_st_t;
  sbs_buf_st_t s_q, s_d;
  logic push, pop;
  assign in_ready  = (s_q.cnt != 2'h2);
  assign out_valid = (s_q.cnt != 2'h0);
  assign out_data  = s_q.d0;
  assign push = in_valid && in_ready;
  assign pop  = out_valid && out_ready;
  always_comb begin
    s_d = s_q;
    if (pop) begin
      s_d.d0 = s_q.d1;
    end
    if (push) begin
      if (s_q.cnt == 2'h0 || (s_q.cnt == 2'h1 && pop)) begin
        s_d.d0 = in_data;
      end else begin
        s_d.d1 = in_data;
      end
    end
    s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : sbs_buf2

// *** testbench/sbs_ctrl_model.sv ***
// Controller model driving the burst SRAM bus
`timescale 1ns/1ps
module sbs_ctrl_model (
  input  wire logic clk,
  output logic [18:0] addr,
  output logic        addr_load,
  output logic        sel,
  output logic        adv_n,
  output logic        write_n,
  output logic [3:0]  lanes_n,
  output logic [35:0] wdata
);
  initial begin
    {addr, addr_load, sel, adv_n, write_n, lanes_n, wdata} = {19'h0, 4'h3, 4'hf, 36'h0};
  end
  task automatic burst(input logic wr, input logic s, input logic [1:0] a, input int n,
                       input logic [3:0] ln, input logic [35:0] d);
    @(negedge clk);
    {addr, addr_load, sel, write_n, lanes_n, wdata} = {19'(a), 1'b1, s, !wr, ln, d};
    // Write data follows the load by one cycle; reads advance n-1 times
    for (int i = 0; i < (wr ? n : n - 1); i++) begin
      @(negedge clk);
      {addr_load, adv_n} = 2'b00;
      wdata = d + 36'(i);
    end
    @(negedge clk);
    {addr_load, sel, adv_n, write_n, lanes_n, wdata} = {4'h3, 4'hf, ~wdata};
  endtask : burst
endmodule : sbs_ctrl_model

// *** testbench/sbs_sram_test.sv ***
// Self-checking bench for the burst SRAM sequencer
`timescale 1ns/1ps
module sbs_sram_test;
  localparam logic [35:0] D = 36'h1_2345_6700;
  localparam logic [35:0] M = 36'h0_07fc_01ff;
  logic ref_clk = 0, rstn = 0, order = 0, oe_n = 0;
  logic [18:0] addr;
  logic addr_load, sel, adv_n, write_n, data_oe_n, rd_valid, cfg_ready;
  logic [3:0] lanes_n;
  logic [35:0] wdata, rd_data, dout;
  int err_count = 0, tests_run = 0;
  always #5 ref_clk = ~ref_clk;
  sbs_ctrl_model m (.clk(ref_clk), .addr(addr), .addr_load(addr_load), .sel(sel),
    .adv_n(adv_n), .write_n(write_n), .lanes_n(lanes_n), .wdata(wdata));
  sbs_sram DUT (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .addr_load(addr_load),
    .chip_enable_n(~sel), .second_select_n(~sel), .high_select(sel),
    .burst_advance_n(adv_n), .write_n(write_n), .byte_lane_write_n(lanes_n),
    .burst_order_select(order), .sleep_request(1'b0), .output_enable_n(oe_n),
    .data_in(wdata), .data_out(dout), .data_oe_n(data_oe_n), .rd_valid(rd_valid),
    .rd_ready(1'b1), .rd_data(rd_data), .cfg_ready(cfg_ready));
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Order set in reset, wait config
  task automatic restart(input logic o);
    @(negedge ref_clk);
    {rstn, order} = {1'b0, o};
    repeat (10) @(negedge ref_clk);
    rstn = 1;
    for (int i = 0; i < 20 && cfg_ready !== 1'b1; i++) @(negedge ref_clk);
    m.burst(1'b1, 1'b1, 2'd0, 4, 4'h0, D);
  endtask : restart
  task automatic rd_burst(input logic [1:0] a, input int n, input logic [35:0] w0);
    logic [35:0] got[$];
    logic [1:0] k;
    fork
      m.burst(1'b0, 1'b1, a, n, 4'hf, D);
      for (int t = 0; t < 30 && got.size() < n; t++) begin
        @(negedge ref_clk);
        if (rd_valid === 1'b1) got.push_back(rd_data);
      end
    join
    for (int i = 0; i < n; i++) begin
      k = order ? a ^ 2'(i) : a + 2'(i);
      check(got[i], k == 0 ? w0 : D + 36'(k));
    end
    check(dout, k == 0 ? w0 : D + 36'(k));
  endtask : rd_burst
  task automatic t_desel;
    int seen = 0;
    check(36'(data_oe_n), 36'h0);
    oe_n = 1;
    #1;
    check(36'(data_oe_n), 36'h1);
    oe_n = 0;
    fork
      m.burst(1'b0, 1'b0, 2'd1, 2, 4'hf, D);
      repeat (10) @(negedge ref_clk) if (rd_valid === 1'b1) seen++;
    join
    check(36'(seen), 36'h0);
    check(36'(data_oe_n), 36'h1);
  endtask : t_desel
  task automatic results;
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial begin
    #100000;
    err_count++;
    results;
  end
  initial begin
    restart(1'b0);
    rd_burst(2'd1, 5, D);
    t_desel;
    m.burst(1'b1, 1'b1, 2'd0, 1, 4'b1010, 36'hf_ffff_ffff);
    rd_burst(2'd0, 1, D | M);
    restart(1'b1);
    rd_burst(2'd2, 4, D);
    results;
  end
endmodule : sbs_sram_test
